//--- design/pwm_command_fault_monitor.sv
// PWM command fault monitor: measures the command and gates the RF drive
`timescale 1ns/10ps
`default_nettype none
module pwm_command_fault_monitor #(
   parameter int unsigned PAUSE_CYC_P  = pwm_monitor_pkg::PAUSE_CYC,
   parameter int unsigned PERMIT_CYC_P = pwm_monitor_pkg::PERMIT_CYC,
   parameter int unsigned BLINK_CYC_P  = pwm_monitor_pkg::BLINK_CYC,
   parameter int unsigned CW_CYC_P     = pwm_monitor_pkg::CW_CYC
) (
   // Clock and reset
   input  wire logic                       REF_CLK,
   input  wire logic                       RST,
   // Command and sensors, asynchronous pins
   input  wire logic                       PWM_CMD,
   input  wire pwm_monitor_pkg::fault_in_s FAULT_IN,
   input  wire logic [6:0]                 RELATIVE_HUMIDITY_READING,
   // Drive and indications
   output var  logic                       RF_DRIVE_OUT,
   output var  logic                       READY_LAMP,
   output var  logic                       SHUTTER_LAMP,
   output var  logic                       LASER_READY,
   output var  logic                       FAULT_DETECTED
);
   import pwm_monitor_pkg::*;

   // Two-stage synchronisers
   logic [11:0] sync1_q, sync2_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {PWM_CMD, FAULT_IN, RELATIVE_HUMIDITY_READING};
         sync2_q <= sync1_q;
      end
   end
   wire logic       pwm_s   = sync2_q[11];
   wire fault_in_s  flt_s   = sync2_q[10:7];
   // Humidity word is taken only once two samples agree, so a reading
   // caught while its bits change never reaches the limit compare
   logic [6:0] rh_prev_q, rh_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rh_prev_q <= '0;
         rh_q      <= '0;
      end else begin
         rh_prev_q <= sync2_q[6:0];
         if (sync2_q[6:0] == rh_prev_q) rh_q <= sync2_q[6:0];
      end
   end
   wire logic [6:0] rh_s    = rh_q;

   // Period and high-time measurement
   logic pwm_d1_q;
   cyc_t per_cnt_q, high_cnt_q, run_q, per_q, high_q;
   logic meas_ok_q;
   wire logic rise = pwm_s & ~pwm_d1_q;
   wire logic fall = ~pwm_s & pwm_d1_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pwm_d1_q   <= 1'b0;
         per_cnt_q  <= '0;
         high_cnt_q <= '0;
         run_q      <= '0;
         per_q      <= CYC_ALL;
         high_q     <= '0;
         meas_ok_q  <= 1'b0;
      end else begin
         pwm_d1_q <= pwm_s;
         if (rise) begin
            per_q      <= per_cnt_q;
            high_q     <= high_cnt_q;
            meas_ok_q  <= 1'b1;
            per_cnt_q  <= cyc_t'(1);
            high_cnt_q <= cyc_t'(1);
         end else begin
            meas_ok_q <= 1'b0;
            if (per_cnt_q != CYC_ALL) per_cnt_q <= per_cnt_q + cyc_t'(1);
            if (pwm_s && high_cnt_q != CYC_ALL)
               high_cnt_q <= high_cnt_q + cyc_t'(1);
         end
         if (!pwm_s) run_q <= '0;
         else if (run_q != CYC_ALL) run_q <= run_q + cyc_t'(1);
      end
   end

   // Limit evaluation per completed period; constant-high run checked every cycle
   wire logic [30:0] hi8  = {high_q, 3'b000};
   wire logic [30:0] per3 = {3'b000, per_q} + {2'b00, per_q, 1'b0};
   wire logic freq_bad  = per_q < PERIOD_MIN;
   wire logic duty_bad  = hi8 > per3;
   wire logic pulse_bad = high_q > PULSE_MAX;
   wire logic cw_now    = run_q >= cyc_t'(CW_CYC_P);

   logic freq_q, duty_q, pulse_q, cw_q, cw_clamp_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         freq_q     <= 1'b0;
         duty_q     <= 1'b0;
         pulse_q    <= 1'b0;
         cw_q       <= 1'b0;
         cw_clamp_q <= 1'b0;
      end else begin
         if (meas_ok_q) begin
            freq_q  <= freq_bad;
            duty_q  <= duty_bad;
            pulse_q <= pulse_bad;
         end
         if (cw_now) begin
            cw_q       <= 1'b1;
            cw_clamp_q <= 1'b1;
         end else if (fall) begin
            cw_q <= 1'b0;
         end else if (meas_ok_q && !duty_bad && !pulse_bad) begin
            cw_clamp_q <= 1'b0;
         end
      end
   end

   // Per-pulse length cap from the last measured period
   wire cyc_t cap_half = per_q >> 1;
   wire cyc_t cap_ns   = (per_q == NS_PERIOD) ? (per_q >> 4)
                                              : cyc_t'(per_q / 20);
   wire cyc_t cap_a = (duty_q | cw_clamp_q) ? cap_half : CYC_ALL;
   wire cyc_t cap_b = pulse_q ? PULSE_CAP : CYC_ALL;
   wire cyc_t cap_c = flt_s.no_strike ? cap_ns : CYC_ALL;
   wire cyc_t cap_ab = (cap_a < cap_b) ? cap_a : cap_b;
   wire cyc_t cap    = (cap_ab < cap_c) ? cap_ab : cap_c;

   // Ready delay before lasing is permitted
   logic [31:0] permit_cnt_q;
   wire logic permit = permit_cnt_q >= PERMIT_CYC_P;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) permit_cnt_q <= '0;
      else if (!flt_s.ready_state) permit_cnt_q <= '0;
      else if (!permit) permit_cnt_q <= permit_cnt_q + 32'h0000_0001;
   end

   // Latched service faults, held until reset
   logic rf_lat_q, pc_lat_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rf_lat_q <= 1'b0;
         pc_lat_q <= 1'b0;
      end else begin
         if (flt_s.rf_drive) rf_lat_q <= 1'b1;
         if (flt_s.precharge_miss) pc_lat_q <= 1'b1;
      end
   end

   wire logic rh_halt = rh_s >= RH_HALT;
   wire logic lim_flt = duty_q | pulse_q | cw_q;
   wire logic lase_en = permit & ~rh_halt & ~freq_q & ~cw_q
                        & ~rf_lat_q & ~pc_lat_q;
   wire logic drive_d = pwm_s & lase_en & (run_q < cap);

   // Blink time base
   logic [31:0] tb_cnt_q;
   logic        phase_q;
   wire logic   tick = tb_cnt_q >= BLINK_CYC_P - 1;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         tb_cnt_q <= '0;
         phase_q  <= 1'b0;
      end else if (tick) begin
         tb_cnt_q <= '0;
         phase_q  <= ~phase_q;
      end else begin
         tb_cnt_q <= tb_cnt_q + 32'h0000_0001;
      end
   end

   // Blink code engines: lamp 0 ready, lamp 1 shutter
   wire logic [1:0] code_act = {lim_flt, rf_lat_q | pc_lat_q};
   wire logic [3:0] code_num [2];
   assign code_num[0] = pc_lat_q ? PC_BLINKS : RF_BLINKS;
   assign code_num[1] = DUTY_BLINKS;
   wire logic [1:0] code_lamp;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_code
         blink_e      st_q;
         logic [3:0]  n_q;
         logic [31:0] p_q;
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               st_q <= BK_IDLE;
               n_q  <= '0;
               p_q  <= '0;
            end else begin
               case (st_q)
                  BK_IDLE: if (code_act[g] && tick) begin
                     st_q <= BK_ON;
                     n_q  <= code_num[g];
                  end
                  BK_ON: if (tick) begin
                     st_q <= BK_OFF;
                     n_q  <= n_q - 4'h1;
                  end
                  BK_OFF: if (tick) begin
                     if (n_q != 4'h0) st_q <= BK_ON;
                     else begin
                        st_q <= BK_PAUSE;
                        p_q  <= '0;
                     end
                  end
                  BK_PAUSE: if (p_q >= PAUSE_CYC_P) begin
                     st_q <= BK_IDLE;
                  end else begin
                     p_q <= p_q + 32'h0000_0001;
                  end
                  default: st_q <= BK_IDLE;
               endcase
            end
         end
         assign code_lamp[g] = (st_q == BK_ON);
      end
   endgenerate

   // Registered outputs
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RF_DRIVE_OUT   <= 1'b0;
         READY_LAMP     <= 1'b0;
         SHUTTER_LAMP   <= 1'b0;
         LASER_READY    <= 1'b0;
         FAULT_DETECTED <= 1'b0;
      end else begin
         RF_DRIVE_OUT   <= drive_d;
         READY_LAMP     <= code_act[0] ? code_lamp[0]
                                       : flt_s.ready_state;
         SHUTTER_LAMP   <= flt_s.no_strike ? phase_q
                                           : code_lamp[1];
         LASER_READY    <= flt_s.ready_state & ~pc_lat_q;
         FAULT_DETECTED <= lim_flt | flt_s.no_strike;
      end
   end
endmodule : pwm_command_fault_monitor
`default_nettype wire

//--- design/pwm_monitor_pkg.sv
// Constants and types for the PWM command fault monitor
package pwm_monitor_pkg;
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned CW_W         = 28;
   typedef logic [CW_W-1:0] cyc_t;
   // Limits in their own units
   localparam int unsigned FREQ_MAX_HZ  = 100_000;
   localparam int unsigned PULSE_MAX_US = 1000;
   localparam int unsigned PULSE_CAP_US = 600;
   localparam int unsigned NS_FREQ_HZ   = 5_000;
   localparam int unsigned PAUSE_S      = 4;
   localparam int unsigned PERMIT_S     = 5;
   localparam int unsigned BLINK_MS     = 250;
   localparam int unsigned CW_MS        = 10;
   localparam logic [6:0]  RH_HALT      = 7'h5F;
   localparam logic [3:0]  RF_BLINKS    = 4'h4;
   localparam logic [3:0]  PC_BLINKS    = 4'h5;
   localparam logic [3:0]  DUTY_BLINKS  = 4'h3;
   // Derived cycle counts
   localparam cyc_t PERIOD_MIN = cyc_t'(CLK_HZ / FREQ_MAX_HZ);
   localparam cyc_t PULSE_MAX  = cyc_t'(CLK_HZ / 1_000_000 * PULSE_MAX_US);
   localparam cyc_t PULSE_CAP  = cyc_t'(CLK_HZ / 1_000_000 * PULSE_CAP_US);
   localparam cyc_t NS_PERIOD  = cyc_t'(CLK_HZ / NS_FREQ_HZ);
   localparam int unsigned PAUSE_CYC  = CLK_HZ * PAUSE_S;
   localparam int unsigned PERMIT_CYC = CLK_HZ * PERMIT_S;
   localparam int unsigned BLINK_CYC  = CLK_HZ / 1000 * BLINK_MS;
   localparam int unsigned CW_CYC     = CLK_HZ / 1000 * CW_MS;
   localparam cyc_t CYC_ALL = '1;

   typedef enum logic [1:0] {
      BK_IDLE  = 2'b00,
      BK_ON    = 2'b01,
      BK_OFF   = 2'b10,
      BK_PAUSE = 2'b11
   } blink_e;

   typedef struct packed {
      logic rf_drive;
      logic precharge_miss;
      logic no_strike;
      logic ready_state;
   } fault_in_s;
endpackage : pwm_monitor_pkg

//--- dv/pwm_host.sv
// Host controller model: free-running PWM command of set period and high time
`timescale 1ns/10ps
`default_nettype none
module pwm_host (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] per,
   input  wire logic [31:0] hi,
   output var  logic        pwm
);
   logic [31:0] cnt_q;
   // High time at or above the period gives a constant high command
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'h0;
         pwm   <= 1'b0;
      end else begin
         cnt_q <= (cnt_q + 32'h1 >= per) ? 32'h0 : cnt_q + 32'h1;
         pwm   <= (cnt_q < hi);
      end
   end
endmodule : pwm_host
`default_nettype wire

//--- dv/pwm_monitor_checker_assertions.sv
// Concurrent checks on the ports of the PWM command fault monitor
`timescale 1ns/10ps
`default_nettype none
module pwm_monitor_checker #(
   parameter int unsigned BLINK_CYC_P = 10,
   parameter int unsigned CW_CYC_P    = 2000
) (
   // Clock, reset and inputs
   input wire logic                       REF_CLK,
   input wire logic                       RST,
   input wire logic                       PWM_CMD,
   input wire pwm_monitor_pkg::fault_in_s FAULT_IN,
   input wire logic [6:0]                 RELATIVE_HUMIDITY_READING,
   // Outputs
   input wire logic                       RF_DRIVE_OUT,
   input wire logic                       READY_LAMP,
   input wire logic                       SHUTTER_LAMP,
   input wire logic                       LASER_READY,
   input wire logic                       FAULT_DETECTED
);
   import pwm_monitor_pkg::*;
   localparam int BLW = 2 * BLINK_CYC_P + 4;
   logic [15:0] drv_run_q;
   logic [15:0] cmd_run_q;
   wire logic   rh_hi = (RELATIVE_HUMIDITY_READING >= RH_HALT);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // Lengths of the present high runs of drive and command
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         drv_run_q <= 16'h0000;
         cmd_run_q <= 16'h0000;
      end else begin
         drv_run_q <= RF_DRIVE_OUT ? drv_run_q + 16'h0001 : 16'h0000;
         cmd_run_q <= PWM_CMD ? cmd_run_q + 16'h0001 : 16'h0000;
      end
   end
   property p_humid; rh_hi [*6] |-> !RF_DRIVE_OUT; endproperty
   a_humid: assert property (p_humid)
      else $error("drive at high humidity");
   property p_rf; FAULT_IN.rf_drive [*6] |-> !RF_DRIVE_OUT; endproperty
   a_rf: assert property (p_rf)
      else $error("drive after rf fault");
   property p_pchg; FAULT_IN.precharge_miss [*6] |-> !LASER_READY; endproperty
   a_pchg: assert property (p_pchg)
      else $error("ready with precharge fault");
   property p_permit;
      !FAULT_IN.ready_state [*6] |-> !LASER_READY && !RF_DRIVE_OUT;
   endproperty
   a_permit: assert property (p_permit)
      else $error("ready or drive while not ready");
   property p_cap; {12'h000, drv_run_q} <= PULSE_CAP; endproperty
   a_cap: assert property (p_cap)
      else $error("drive pulse too long");
   property p_cw; (cmd_run_q > CW_CYC_P + 6) |-> !RF_DRIVE_OUT; endproperty
   a_cw: assert property (p_cw)
      else $error("drive during constant high");
   property p_lag; $rose(RF_DRIVE_OUT) |-> $past(PWM_CMD, 3); endproperty
   a_lag: assert property (p_lag)
      else $error("drive without command");
   property p_nslamp;
      FAULT_IN.no_strike [*6] |->
         ##[1:BLW] ($changed(SHUTTER_LAMP) || !FAULT_IN.no_strike);
   endproperty
   a_nslamp: assert property (p_nslamp)
      else $error("shutter lamp not flashing");
endmodule : pwm_monitor_checker
bind pwm_command_fault_monitor pwm_monitor_checker #(
   .BLINK_CYC_P(BLINK_CYC_P), .CW_CYC_P(CW_CYC_P)) chk_u (
   .REF_CLK(REF_CLK), .RST(RST), .PWM_CMD(PWM_CMD), .FAULT_IN(FAULT_IN),
   .RELATIVE_HUMIDITY_READING(RELATIVE_HUMIDITY_READING),
   .RF_DRIVE_OUT(RF_DRIVE_OUT), .READY_LAMP(READY_LAMP),
   .SHUTTER_LAMP(SHUTTER_LAMP), .LASER_READY(LASER_READY),
   .FAULT_DETECTED(FAULT_DETECTED));
`default_nettype wire

//--- dv/tb_pwm_command_fault_monitor.sv
// Testbench for the PWM command fault monitor
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_command_fault_monitor;
   import pwm_monitor_pkg::*;
   logic        clk, rst, pwm, drv, rdy_l, sht_l, lrdy, fdet;
   fault_in_s   fin;
   logic [6:0]  rh;
   logic [31:0] per, hi;
   int          num_errors, cmp_count, mx, rs, rl, sl;
   pwm_command_fault_monitor #(.PAUSE_CYC_P(200), .PERMIT_CYC_P(100),
      .BLINK_CYC_P(10), .CW_CYC_P(2000)) dut_u (.REF_CLK(clk), .RST(rst),
      .PWM_CMD(pwm), .FAULT_IN(fin), .RELATIVE_HUMIDITY_READING(rh),
      .RF_DRIVE_OUT(drv), .READY_LAMP(rdy_l), .SHUTTER_LAMP(sht_l),
      .LASER_READY(lrdy), .FAULT_DETECTED(fdet));
   pwm_host host_u (.clk(clk), .rst(rst), .per(per), .hi(hi), .pwm(pwm));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic stuck();
      num_errors++;
      $display("[FAIL] %0t wait timed out got %0h exp %0h", $time, 1, 0);
      end_sim();
   endtask : stuck
   // Waits until the chosen lamp has been dark for 100 cycles
   task automatic quiet(input bit use_sht);
      int low, n;
      low = 0;
      n = 0;
      while (low < 100 && n < 2000) begin
         @(negedge clk);
         n++;
         low = ((use_sht ? sht_l : rdy_l) === 1'b0) ? low + 1 : 0;
      end
      if (low < 100) stuck();
   endtask : quiet
   task automatic setp(input int p, input int h, input int s);
      @(posedge clk);
      per <= p;
      hi  <= h;
      repeat (s) @(posedge clk);
   endtask : setp
   // Longest drive run and rising edges of drive and lamps over n cycles
   task automatic meas(input int n);
      logic pd, pr, ps;
      int   run;
      mx = 0; rs = 0; rl = 0; sl = 0; run = 0;
      pd = drv; pr = rdy_l; ps = sht_l;
      repeat (n) begin
         @(negedge clk);
         run = (drv === 1'b1) ? run + 1 : 0;
         if (run > mx) mx = run;
         rs += int'(drv === 1'b1 && pd !== 1'b1);
         rl += int'(rdy_l === 1'b1 && pr !== 1'b1);
         sl += int'(sht_l === 1'b1 && ps !== 1'b1);
         pd = drv; pr = rdy_l; ps = sht_l;
      end
   endtask : meas
   task automatic t_duty();
      setp(1000, 200, 3000); meas(3000);
      chk(mx, 200);
      chk(lrdy, 1'b1);
      setp(1000, 375, 3000); meas(100);
      chk(fdet, 1'b0);
      setp(1000, 450, 3000); meas(3000);
      chk(mx, 450);
      chk(fdet, 1'b1);
      setp(1000, 600, 3000); meas(3000);
      chk(mx, 500);
      quiet(1'b1);
      meas(260);
      chk(sl, 3);
   endtask : t_duty
   task automatic t_cw();
      setp(1, 1, 3000); meas(500);
      chk(mx, 0);
      chk(fdet, 1'b1);
      setp(1000, 200, 3000); meas(3000);
      chk(mx, 200);
   endtask : t_cw
   task automatic t_freq();
      setp(499, 100, 2000); meas(2000);
      chk(rs, 0);
      setp(500, 100, 2000); meas(2000);
      chk(mx, 100);
   endtask : t_freq
   task automatic t_hum();
      rh <= 7'h5F;
      setp(1000, 200, 2000); meas(2000);
      chk(rs, 0);
      rh <= 7'h5E;
      setp(1000, 200, 2000); meas(2000);
      chk(mx, 200);
   endtask : t_hum
   // Ready dropped, then raised one cycle after a command rise
   task automatic t_permit();
      int n;
      setp(500, 180, 1500);
      fin.ready_state <= 1'b0;
      repeat (10) @(posedge clk);
      meas(1000);
      chk(rs, 0);
      chk(lrdy, 1'b0);
      n = 0;
      while (pwm !== 1'b0 && n < 600) begin
         @(posedge clk);
         n++;
      end
      while (pwm !== 1'b1 && n < 1200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 1200) stuck();
      fin.ready_state <= 1'b1;
      meas(300);
      chk(mx, 79);
   endtask : t_permit
   task automatic t_nostrike();
      fin.no_strike <= 1'b1;
      setp(10000, 1000, 12000); meas(10000);
      chk(mx, 625);
      chk(fdet, 1'b1);
      chk(sl, 500);
      setp(2000, 400, 3000); meas(2000);
      chk(mx, 100);
      setp(2000, 80, 3000); meas(2000);
      chk(mx, 80);
      fin.no_strike <= 1'b0;
      setp(2000, 400, 3000); meas(2000);
      chk(mx, 400);
   endtask : t_nostrike
   task automatic t_latch();
      fin.rf_drive <= 1'b1;
      setp(1000, 200, 1000);
      quiet(1'b0);
      meas(280);
      chk(rl, 4);
      chk(rs, 0);
      fin.precharge_miss <= 1'b1;
      setp(1000, 200, 1000);
      quiet(1'b0);
      meas(300);
      chk(rl, 5);
      chk(lrdy, 1'b0);
   endtask : t_latch
   task automatic end_sim();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   initial begin
      rst = 1'b1; per = 0; hi = 0; rh = 7'h00; fin = 4'h1;
      num_errors = 0; cmp_count = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_duty(); t_cw(); t_freq(); t_hum(); t_permit(); t_nostrike();
      t_latch();
      end_sim();
   end
endmodule : tb_pwm_command_fault_monitor
`default_nettype wire
